// ### est_consts.svh
/*
  constants for the eight channel sequence timer: register offsets, field
  positions, reset values and timing figures.
  assumes inclusion by bare name from the package and modules.
*/
`ifndef EST_CONSTS_SVH
`define EST_CONSTS_SVH

// ==========================================================================
// timing
`define EST_CLK_HZ          10000000
`define EST_TICK_MS         10
`define EST_TICK_CYCLES     ((`EST_CLK_HZ / 1000) * `EST_TICK_MS)

// ==========================================================================
// geometry
`define EST_NCHAN           8
`define EST_CNT_W           31
`define EST_IDX_W           3

// ==========================================================================
// register byte offsets
`define EST_OFS_CMD         12'h000
`define EST_OFS_PRESET      12'h004
`define EST_OFS_DONE        12'h008
`define EST_OFS_MODE        12'h00c
`define EST_OFS_OUT         12'h010
`define EST_OFS_CTRL        12'h014
`define EST_OFS_CNT0        12'h020
`define EST_OFS_CNT_LAST    12'h03c

// ==========================================================================
// command and control register fields
`define EST_CMD_IDX_LSB     0
`define EST_CMD_OP_LSB      4
`define EST_CMD_OP_W        3
`define EST_CTRL_START_BIT  0

// ==========================================================================
// reset values
`define EST_RST_WORD        32'h0000_0000

`endif

// ### est_pkg.sv
/*
  types for the eight channel sequence timer.
  assumes est_consts.svh is in the include path.
*/
`include "est_consts.svh"

package est_pkg;

  // command opcodes written by the engine
  typedef enum logic [`EST_CMD_OP_W-1:0] {
    EST_OP_NONE     = 3'h0,
    EST_OP_ARM      = 3'h1,
    EST_OP_DLY_SET  = 3'h2,
    EST_OP_DLY_CLR  = 3'h3,
    EST_OP_FREE     = 3'h4
  } est_op_e;

  // one command to a single channel
  typedef struct packed {
    logic                  arm;
    logic                  free;
    logic                  dly;
    logic                  dly_level;
    logic [`EST_CNT_W-1:0] preset;
  } est_cmd_s;

  // one channel's visible state
  typedef struct packed {
    logic                  done;
    logic                  contact;
    logic [`EST_CNT_W-1:0] count;
  } est_stat_s;

endpackage : est_pkg

// ### est_channel.sv
/*
  one timer channel: counter, preset buffer, done flag, delayed-output bit.
  assumes commands are one-cycle pulses and tick is a one-cycle enable.
*/
`timescale 1ns/1ns
`default_nettype none
`include "est_consts.svh"

module est_channel
  import est_pkg::*;
#(
  parameter int CNT_W = `EST_CNT_W
) (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       restart,
  input  wire logic       tick,
  input  wire est_cmd_s   cmd,
  // state
  output est_stat_s       stat,
  output logic            dly_out
);

  // ========================================================================
  // state
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] preset;
  logic [CNT_W-1:0] next_preset;
  logic             done;
  logic             next_done;
  logic             contact;
  logic             next_contact;
  logic             dly;
  logic             next_dly;
  logic             level;
  logic             next_level;
  logic             out_bit;
  logic             next_out_bit;
  logic             halted;

  assign halted = contact && (count == preset);

  // ========================================================================
  // next state
  always_comb begin
    next_count   = count;
    next_preset  = preset;
    next_done    = done;
    next_contact = contact;
    next_dly     = dly;
    next_level   = level;
    next_out_bit = out_bit;
    if (restart) begin
      next_count   = '0;                        // [R03]
      next_contact = 1'b0;                      // [R03]
      next_done    = 1'b0;
      next_dly     = 1'b0;
    end else if (cmd.arm) begin
      next_preset  = cmd.preset;                // [R05]
      next_count   = '0;                        // [R05]
      next_contact = 1'b1;                      // [R04]
      next_done    = 1'b0;                      // [R06]
      next_dly     = cmd.dly;
      next_level   = cmd.dly_level;
    end else if (cmd.free) begin
      next_count   = '0;                        // [R09]
      next_contact = 1'b0;                      // [R09] [R11]
      next_dly     = 1'b0;
    end else if (halted) begin
      if (!done) begin
        next_done = 1'b1;                       // [R08]
        if (dly) begin
          next_out_bit = level;                 // [R12]
        end
      end
    end else if (tick) begin
      next_count = count + 1'b1;                // [R02] [R07] [R14]
    end
  end

  // ========================================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count   <= '0;
      preset  <= '0;
      done    <= 1'b0;
      contact <= 1'b0;
      dly     <= 1'b0;
      level   <= 1'b0;
      out_bit <= 1'b0;
    end else begin
      count   <= next_count;
      preset  <= next_preset;
      done    <= next_done;
      contact <= next_contact;
      dly     <= next_dly;
      level   <= next_level;
      out_bit <= next_out_bit;
    end
  end

  assign stat.done    = done;
  assign stat.contact = contact;
  assign stat.count   = count;
  assign dly_out      = out_bit;

endmodule // est_channel

`default_nettype wire

// ### est_timer.sv
/*
  eight channel sequence timer with an ahb-lite register slave.
  assumes one 10 mhz clock, single word transfers, engine writes commands.
*/
// Overview of operation
// [R01] eight channels, own counter, preset, done
// [R02] 31-bit counter, plus one per tick
// [R03] program start: all channels free-running
// [R04] two modes: free-running and contact-output
// [R05] arm: store preset, clear, count contact
// [R06] arming forces done flag low
// [R07] contact mode halts when count equals preset
// [R08] done rises once, holds while halted
// [R09] return: clear, restart, free-running
// [R10] arming never stalls the engine
// [R11] return keeps done flag unchanged
// [R12] delayed output drives target bit on done
// [R13] engine gives preset in 10 ms ticks
// [R14] free-running counter wraps silently
`timescale 1ns/1ns
`default_nettype none
`include "est_consts.svh"

module est_timer
  import est_pkg::*;
#(
  parameter int NCHAN       = `EST_NCHAN,
  parameter int CNT_W       = `EST_CNT_W,
  parameter int TICK_CYCLES = `EST_TICK_CYCLES
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // timer outputs
  output logic [NCHAN-1:0]       channel_done_flag,
  output logic [NCHAN-1:0]       delayed_out
);

  // ========================================================================
  // tick divider
  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  logic [TW-1:0] div;
  logic [TW-1:0] next_div;
  logic          tick;
  logic          restart;

  assign tick = (div == TICK_LAST);

  always_comb begin
    next_div = tick ? '0 : div + 1'b1;          // [R02]
    if (restart) begin
      next_div = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= '0;
    end else begin
      div <= next_div;
    end
  end

  // ========================================================================
  // bus address phase capture
  logic        wr_pend;
  logic        next_wr_pend;
  logic [11:0] wr_addr;
  logic [11:0] next_wr_addr;
  logic        access;

  assign access = hsel && hready && htrans[1];

  always_comb begin
    next_wr_pend = access && hwrite;
    next_wr_addr = access ? haddr[11:0] : wr_addr;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
    end
  end

  // ========================================================================
  // preset holding register and command decode
  logic [CNT_W-1:0]     preset;
  logic [CNT_W-1:0]     next_preset;
  logic                 cmd_wr;
  logic [`EST_IDX_W-1:0] cmd_idx;
  est_op_e              cmd_op;

  assign cmd_wr  = wr_pend && (wr_addr == `EST_OFS_CMD);
  assign cmd_idx = hwdata[`EST_CMD_IDX_LSB +: `EST_IDX_W];
  assign cmd_op  = est_op_e'(hwdata[`EST_CMD_OP_LSB +: `EST_CMD_OP_W]);
  assign restart = wr_pend && (wr_addr == `EST_OFS_CTRL) && hwdata[`EST_CTRL_START_BIT];

  always_comb begin
    next_preset = preset;
    if (wr_pend && (wr_addr == `EST_OFS_PRESET)) begin
      next_preset = hwdata[CNT_W-1:0];          // [R13]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preset <= '0;
    end else begin
      preset <= next_preset;
    end
  end

  // ========================================================================
  // channels
  localparam int IW = `EST_IDX_W;
  est_stat_s        stat [NCHAN];
  logic [NCHAN-1:0] mode_bits;

  genvar g;
  generate
    for (g = 0; g < NCHAN; g++) begin : gen_chan
      est_cmd_s ccmd;
      logic     hit;
      assign hit            = cmd_wr && (cmd_idx == IW'(g));   // [R01]
      assign ccmd.arm       = hit && ((cmd_op == EST_OP_ARM) || (cmd_op == EST_OP_DLY_SET) ||
                                      (cmd_op == EST_OP_DLY_CLR));     // [R05]
      assign ccmd.free      = hit && (cmd_op == EST_OP_FREE);          // [R09]
      assign ccmd.dly       = (cmd_op == EST_OP_DLY_SET) || (cmd_op == EST_OP_DLY_CLR);
      assign ccmd.dly_level = (cmd_op == EST_OP_DLY_SET);              // [R12]
      assign ccmd.preset    = preset;

      est_channel #(
        .CNT_W (CNT_W)
      ) u_chan (
        .hclk    (hclk),
        .hresetn (hresetn),
        .restart (restart),
        .tick    (tick),
        .cmd     (ccmd),
        .stat    (stat[g]),
        .dly_out (delayed_out[g])
      );

      assign channel_done_flag[g] = stat[g].done;
      assign mode_bits[g]         = stat[g].contact;           // [R04]
    end
  endgenerate

  // ========================================================================
  // read data
  logic [31:0] next_hrdata;
  logic [31:0] rdata;

  always_comb begin
    rdata = `EST_RST_WORD;
    if (haddr[11:0] == `EST_OFS_PRESET) begin
      rdata = 32'(preset);
    end else if (haddr[11:0] == `EST_OFS_DONE) begin
      rdata = 32'(channel_done_flag);
    end else if (haddr[11:0] == `EST_OFS_MODE) begin
      rdata = 32'(mode_bits);
    end else if (haddr[11:0] == `EST_OFS_OUT) begin
      rdata = 32'(delayed_out);
    end else if ((haddr[11:0] >= `EST_OFS_CNT0) && (haddr[11:0] <= `EST_OFS_CNT_LAST)) begin
      rdata = 32'(stat[haddr[4:2]].count);
    end
    next_hrdata = (access && !hwrite) ? rdata : hrdata;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  assign hreadyout = 1'b1;                      // [R10]
  assign hresp     = 1'b0;

endmodule // est_timer

`default_nettype wire

// ### est_props.sv
/* assertions on the timer's top ports.
   assumes hready is tied to hreadyout. */
`timescale 1ns/1ns
`default_nettype none
`include "est_consts.svh"
module est_props #(
  parameter int NCHAN       = 8,
  parameter int CNT_W       = 31,
  parameter int TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic             hclk,
  input wire logic             hresetn,
  // bus
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [2:0]       hsize,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic [31:0]      hrdata,
  input wire logic             hreadyout,
  input wire logic             hresp,
  // timer
  input wire logic [NCHAN-1:0] channel_done_flag,
  input wire logic [NCHAN-1:0] delayed_out
);
  // ==========
  // command decode
  logic             ph_w, c_hit, r_hit;
  logic [11:0]      ph_a;
  logic [2:0]       c_op, c_idx;
  logic [NCHAN-1:0] d_q, armed, dly, lvl, clr;
  wire              arm_op = c_op inside {3'h1, 3'h2, 3'h3};
  always_comb begin
    clr = r_hit ? '1 : '0;
    if (c_hit && arm_op)
      clr[c_idx] = 1'b1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ph_w, c_hit, r_hit, ph_a, c_op, c_idx} <= '0;
      {d_q, armed, dly, lvl} <= '0;
    end else begin
      ph_w <= hsel & hready & htrans[1] & hwrite;
      ph_a <= haddr[11:0];
      c_hit <= ph_w && ph_a == `EST_OFS_CMD;
      r_hit <= ph_w && ph_a == `EST_OFS_CTRL && hwdata[0];
      c_op <= hwdata[6:4];
      c_idx <= hwdata[2:0];
      d_q <= channel_done_flag;
      if (r_hit)
        armed <= '0;
      else if (c_hit && (arm_op || c_op == 3'h4)) begin
        armed[c_idx] <= arm_op;
        dly[c_idx] <= c_op != 3'h1;
        lvl[c_idx] <= c_op == 3'h2;
      end
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout)
    else $error("wait state seen");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_start_free: assert property ($rose(hresetn) |-> channel_done_flag == '0 && delayed_out == '0)
    else $error("flags set at start");
  a_arm_clears: assert property (c_hit && arm_op |-> !channel_done_flag[c_idx])
    else $error("done not cleared by arm");
  a_free_keeps: assert property (c_hit && c_op == 3'h4 |-> channel_done_flag[c_idx] == d_q[c_idx])
    else $error("done changed by return");
  a_done_holds: assert property ((~channel_done_flag & d_q & ~clr) == '0)
    else $error("done fell without arm");
  a_rise_armed: assert property ((channel_done_flag & ~d_q & ~armed) == '0)
    else $error("done rose while free");
  a_dly_level: assert property (((channel_done_flag & ~d_q & armed & dly) & (delayed_out ^ lvl)) == '0)
    else $error("wrong delayed level");
endmodule // est_props
bind est_timer est_props #(.NCHAN(NCHAN), .CNT_W(CNT_W), .TICK_CYCLES(TICK_CYCLES)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .channel_done_flag(channel_done_flag), .delayed_out(delayed_out));
`default_nettype wire

// ### est_engine.sv
/* ahb-lite master standing in for the sequence engine.
   assumes hready carries the slave's hreadyout. */
`timescale 1ns/1ns
`default_nettype none
module est_engine (
  // bus
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // ==========
  // transfers
  logic hang = 1'b0;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 32);
    q = hrdata;
    hang = hang | (hready !== 1'b1);
  endtask
  function automatic logic [30:0] ticks(int sec, int hun);
    return 31'(sec * 100 + hun);
  endfunction
  task automatic cmd(input logic [2:0] op, k, input logic [30:0] p);
    logic [31:0] q;
    xfer(1'b1, 32'h4, {1'b0, p}, q);
    xfer(1'b1, 32'h0, {25'h0, op, 1'b0, k}, q);
  endtask
endmodule // est_engine
`default_nettype wire

// ### est_timer_tb.sv
/* self-checking bench for est_timer driven by the engine model.
   assumes a 100 ns clock and a tick of four cycles. */
`timescale 1ns/1ns
`default_nettype none
module est_timer_tb;
  // ==========
  // wiring
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q, c0;
  logic [7:0]  done_flag, dly_out;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          c;
  always #50 hclk = ~hclk;
  est_engine eng (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  est_timer #(.TICK_CYCLES(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .channel_done_flag(done_flag),
    .delayed_out(dly_out));
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [31:0] a, exp);
    eng.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic results;
    if (eng.hang)
      n_errors++;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic free_chk(input int k);
    eng.xfer(1'b0, 32'h20 + 4 * k, 32'h0, c0);
    repeat (42) @(posedge hclk);
    rc(32'h20 + 4 * k, c0 + 11);
  endtask
  task automatic wait_done(input int k);
    c = 0;
    do begin
      eng.xfer(1'b0, 32'h8, 32'h0, q);
      c++;
    end while (q[k] !== 1'b1 && c < 100);
    if (q[k] !== 1'b1) begin
      n_errors++;
      results;
    end
  endtask
  // ==========
  // sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(32'h8, 32'h0);
    rc(32'hc, 32'h0);
    for (int k = 0; k < 8; k++)
      free_chk(k);
    $display("test 1 done");
    for (int op = 1; op <= 3; op++) begin
      eng.cmd(3'(op), 3'h5, eng.ticks(0, 6));
      rc(32'hc, 32'h20);
      rc(32'h8, 32'h0);
      wait_done(5);
      repeat (20) @(posedge hclk);
      rc(32'h34, 32'h6);
      @(negedge hclk);
      chk({16'h0, dly_out, done_flag}, op == 2 ? 32'h2020 : 32'h20);
      @(posedge hclk);
    end
    $display("test 2 done");
    eng.cmd(3'h4, 3'h5, 31'h0);
    rc(32'hc, 32'h0);
    rc(32'h8, 32'h20);
    free_chk(5);
    $display("test 3 done");
    eng.cmd(3'h1, 3'h2, eng.ticks(0, 40));
    eng.cmd(3'h1, 3'h3, 31'h0);
    wait_done(3);
    rc(32'h8, 32'h28);
    rc(32'h2c, 32'h0);
    rc(32'hc, 32'hc);
    $display("test 4 done");
    eng.xfer(1'b1, 32'h100, 32'hffff_ffff, q);
    rc(32'h100, 32'h0);
    eng.xfer(1'b1, 32'h14, 32'h1, q);
    rc(32'h8, 32'h0);
    rc(32'hc, 32'h0);
    $display("test 5 done");
    results;
  end
  initial begin
    repeat (60000) @(posedge hclk);
    n_errors++;
    results;
  end
endmodule // est_timer_tb
`default_nettype wire
